// >>> verilog/drf_pkg.sv
// package for the cpu register file: indices, field positions, reset values
package drf_pkg;

  localparam int DRF_NUM_REGS = 28;
  localparam int DRF_IDX_W = 5;
  localparam int DRF_EXT_W = 40;
  localparam int DRF_WORD_W = 32;

  // register indices on the register port
  localparam logic [4:0] DRF_IDX_EXT0 = 5'h00;
  localparam logic [4:0] DRF_IDX_AUX0 = 5'h08;
  localparam logic [4:0] DRF_IDX_PAGE = 5'h10;
  localparam logic [4:0] DRF_IDX_INDA = 5'h11;
  localparam logic [4:0] DRF_IDX_INDB = 5'h12;
  localparam logic [4:0] DRF_IDX_BLEN = 5'h13;
  localparam logic [4:0] DRF_IDX_STACK = 5'h14;
  localparam logic [4:0] DRF_IDX_COND = 5'h15;
  localparam logic [4:0] DRF_IDX_IRQEN = 5'h16;
  localparam logic [4:0] DRF_IDX_IFLAG = 5'h17;
  localparam logic [4:0] DRF_IDX_XFLAG = 5'h18;
  localparam logic [4:0] DRF_IDX_LSTART = 5'h19;
  localparam logic [4:0] DRF_IDX_LEND = 5'h1A;
  localparam logic [4:0] DRF_IDX_LCOUNT = 5'h1B;

  // condition word fields
  localparam int DRF_ST_CARRY = 0;
  localparam int DRF_ST_OVF = 1;
  localparam int DRF_ST_ZERO = 2;
  localparam int DRF_ST_NEG = 3;
  localparam int DRF_ST_UNF = 4;
  localparam int DRF_ST_LOVF = 5;
  localparam int DRF_ST_LUNF = 6;
  localparam int DRF_ST_SAT = 7;
  localparam int DRF_ST_RPT = 8;
  localparam int DRF_ST_CFRZ = 10;
  localparam int DRF_ST_CEN = 11;
  localparam int DRF_ST_CCLR = 12;
  localparam int DRF_ST_GIE = 13;
  localparam logic [31:0] DRF_ST_KEEP = 32'hFFFF_3DFF;
  localparam logic [31:0] DRF_ST_RESET = 32'h0000_0000;

  // interrupt enable mask layout
  localparam int DRF_IE_CPU_LSB = 0;
  localparam int DRF_IE_DMA_LSB = 16;
  localparam int DRF_IE_SRCS = 11;
  localparam logic [31:0] DRF_IE_KEEP = 32'h07FF_07FF;
  localparam logic [31:0] DRF_IE_RESET = 32'h0000_0000;

  localparam logic [31:0] DRF_SAT_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] DRF_SAT_NEG = 32'h8000_0000;
  localparam logic [31:0] DRF_PAGE_MASK = 32'h0000_00FF;
  localparam logic [31:0] DRF_ADDR_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] DRF_WORD_RESET = 32'h0000_0000;

  // result written back by the alu or multiplier
  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic is_float;
    logic [39:0] data;
    logic int_ovf;
    logic ovf_pos;
    logic carry;
    logic unf;
    logic set_flags;
  } drf_result_t;

  // address arithmetic unit write
  typedef struct packed {
    logic valid;
    logic [2:0] sel;
    logic [31:0] data;
  } drf_aux_wr_t;

endpackage

// >>> verilog/drf_cpu_register_file.sv
// multiport cpu register file with condition word, enables and cache controls
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module drf_cpu_register_file
  import drf_pkg::*;
#(
  parameter int NUM_EXT = 8,
  parameter int NUM_AUX = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire drf_result_t alu_res,
  input wire drf_aux_wr_t aux_wr_a,
  input wire drf_aux_wr_t aux_wr_b,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic repeat_running,
  input wire logic [DRF_IE_SRCS-1:0] irq_pending,
  output logic [DRF_IE_SRCS-1:0] cpu_irq_take,
  output logic [DRF_IE_SRCS-1:0] dma_irq_take,
  output logic [7:0] page_sel,
  output logic [23:0] stack_addr,
  output logic cache_fetch_ok,
  output logic cache_update_ok,
  output logic cache_invalidate,
  output logic [39:0] ext_out0
);

  logic [39:0] ext_prec_regs [NUM_EXT];
  logic [31:0] aux_addr_regs [NUM_AUX];
  logic [31:0] data_page_ptr;
  logic [31:0] index_reg_a;
  logic [31:0] index_reg_b;
  logic [31:0] circ_block_len;
  logic [31:0] stack_top_ptr;
  logic [31:0] cpu_condition_word;
  logic [31:0] irq_enable_mask;
  logic [31:0] irq_flag_word;
  logic [31:0] xflag_pin_ctl;
  logic [31:0] loop_start_addr;
  logic [31:0] loop_end_addr;
  logic [31:0] loop_count;

  // register port decode
  wire logic is_ext = reg_addr < DRF_IDX_AUX0;
  wire logic is_aux = (reg_addr >= DRF_IDX_AUX0) && (reg_addr < DRF_IDX_PAGE);
  wire logic [2:0] sub_idx = reg_addr[2:0];
  wire logic wr_cond = reg_wr && (reg_addr == DRF_IDX_COND);
  wire logic wr_stack = reg_wr && (reg_addr == DRF_IDX_STACK);

  // alu result with saturation applied; flags are taken from the raw overflow
  wire logic res_int = alu_res.valid && !alu_res.is_float;
  wire logic do_sat = res_int && alu_res.int_ovf && cpu_condition_word[DRF_ST_SAT];
  wire logic [31:0] sat_word = alu_res.ovf_pos ? DRF_SAT_POS : DRF_SAT_NEG;
  wire logic [31:0] res_word = do_sat ? sat_word : alu_res.data[31:0];
  wire logic res_zero = alu_res.is_float ? (alu_res.data[31:0] == 32'h0000_0000 && alu_res.data[39:32] == 8'h80)
                                         : (res_word == 32'h0000_0000);
  wire logic res_neg = res_word[31];
  wire logic res_ovf = alu_res.int_ovf;

  // next condition word: explicit load wins over a flag update
  logic [31:0] next_cond;
  always_comb begin
    next_cond = cpu_condition_word;
    if (alu_res.valid && alu_res.set_flags) begin
      next_cond[DRF_ST_CARRY] = alu_res.carry;
      next_cond[DRF_ST_OVF] = res_ovf;
      next_cond[DRF_ST_ZERO] = res_zero;
      next_cond[DRF_ST_NEG] = res_neg;
      next_cond[DRF_ST_UNF] = alu_res.unf;
      next_cond[DRF_ST_LOVF] = cpu_condition_word[DRF_ST_LOVF] | res_ovf;
      next_cond[DRF_ST_LUNF] = cpu_condition_word[DRF_ST_LUNF] | alu_res.unf;
    end
    if (wr_cond) begin
      next_cond = reg_wdata;
    end
    next_cond[DRF_ST_RPT] = repeat_running;
    next_cond[DRF_ST_CCLR] = 1'b0;
    next_cond = next_cond & DRF_ST_KEEP;
  end

  // stack pointer: pre-increment on push, post-decrement on pop
  logic [31:0] next_stack;
  always_comb begin
    next_stack = stack_top_ptr;
    if (wr_stack) begin
      next_stack = reg_wdata;
    end else if (stack_push && !stack_pop) begin
      next_stack = stack_top_ptr + 32'h0000_0001;
    end else if (stack_pop && !stack_push) begin
      next_stack = stack_top_ptr - 32'h0000_0001;
    end
  end

  // extended register file; integer write keeps the exponent byte
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
      wire logic port_hit = reg_wr && is_ext && (sub_idx == 3'(gi));
      wire logic res_hit = alu_res.valid && (alu_res.idx == 5'(gi));
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          ext_prec_regs[gi] <= 40'h00_0000_0000;
        end else if (port_hit) begin
          ext_prec_regs[gi][31:0] <= reg_wdata;
        end else if (res_hit && alu_res.is_float) begin
          ext_prec_regs[gi] <= alu_res.data;
        end else if (res_hit) begin
          ext_prec_regs[gi][31:0] <= res_word;
        end
      end
    end
    for (gi = 0; gi < NUM_AUX; gi++) begin : g_aux
      wire logic port_hit = reg_wr && is_aux && (sub_idx == 3'(gi));
      wire logic res_hit = res_int && (alu_res.idx == DRF_IDX_AUX0 + 5'(gi));
      wire logic a_hit = aux_wr_a.valid && (aux_wr_a.sel == 3'(gi));
      wire logic b_hit = aux_wr_b.valid && (aux_wr_b.sel == 3'(gi));
      // cpu writes take priority over the address units; units a then b
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          aux_addr_regs[gi] <= DRF_WORD_RESET;
        end else if (port_hit) begin
          aux_addr_regs[gi] <= reg_wdata;
        end else if (res_hit) begin
          aux_addr_regs[gi] <= res_word;
        end else if (a_hit) begin
          aux_addr_regs[gi] <= aux_wr_a.data;
        end else if (b_hit) begin
          aux_addr_regs[gi] <= aux_wr_b.data;
        end
      end
    end
  endgenerate

  // system registers written from the port or an integer result
  wire logic [4:0] sys_idx = reg_wr ? reg_addr : alu_res.idx;
  wire logic sys_we = reg_wr || res_int;
  wire logic [31:0] sys_data = reg_wr ? reg_wdata : res_word;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_page_ptr <= DRF_WORD_RESET;
      index_reg_a <= DRF_WORD_RESET;
      index_reg_b <= DRF_WORD_RESET;
      circ_block_len <= DRF_WORD_RESET;
      irq_enable_mask <= DRF_IE_RESET;
      irq_flag_word <= DRF_WORD_RESET;
      xflag_pin_ctl <= DRF_WORD_RESET;
      loop_start_addr <= DRF_WORD_RESET;
      loop_end_addr <= DRF_WORD_RESET;
      loop_count <= DRF_WORD_RESET;
    end else if (sys_we) begin
      case (sys_idx)
        DRF_IDX_PAGE: data_page_ptr <= sys_data;
        DRF_IDX_INDA: index_reg_a <= sys_data;
        DRF_IDX_INDB: index_reg_b <= sys_data;
        DRF_IDX_BLEN: circ_block_len <= sys_data;
        DRF_IDX_IRQEN: irq_enable_mask <= sys_data & DRF_IE_KEEP;
        DRF_IDX_IFLAG: irq_flag_word <= sys_data;
        DRF_IDX_XFLAG: xflag_pin_ctl <= sys_data;
        DRF_IDX_LSTART: loop_start_addr <= sys_data;
        DRF_IDX_LEND: loop_end_addr <= sys_data;
        DRF_IDX_LCOUNT: loop_count <= sys_data;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_condition_word <= DRF_ST_RESET;
      stack_top_ptr <= DRF_WORD_RESET;
    end else begin
      cpu_condition_word <= next_cond;
      stack_top_ptr <= next_stack;
    end
  end

  // read mux: every register reads as a 32-bit word
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_ext) begin
      rd_mux = ext_prec_regs[sub_idx][31:0];
    end else if (is_aux) begin
      rd_mux = aux_addr_regs[sub_idx];
    end else begin
      case (reg_addr)
        DRF_IDX_PAGE: rd_mux = data_page_ptr;
        DRF_IDX_INDA: rd_mux = index_reg_a;
        DRF_IDX_INDB: rd_mux = index_reg_b;
        DRF_IDX_BLEN: rd_mux = circ_block_len;
        DRF_IDX_STACK: rd_mux = stack_top_ptr;
        DRF_IDX_COND: rd_mux = cpu_condition_word;
        DRF_IDX_IRQEN: rd_mux = irq_enable_mask;
        DRF_IDX_IFLAG: rd_mux = irq_flag_word;
        DRF_IDX_XFLAG: rd_mux = xflag_pin_ctl;
        DRF_IDX_LSTART: rd_mux = loop_start_addr;
        DRF_IDX_LEND: rd_mux = loop_end_addr;
        DRF_IDX_LCOUNT: rd_mux = loop_count;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // cache permissions follow the freshly committed condition word
  wire logic st_cen = cpu_condition_word[DRF_ST_CEN];
  wire logic st_cfrz = cpu_condition_word[DRF_ST_CFRZ];
  wire logic st_gie = cpu_condition_word[DRF_ST_GIE];
  wire logic [DRF_IE_SRCS-1:0] cpu_en = irq_enable_mask[DRF_IE_CPU_LSB +: DRF_IE_SRCS];
  wire logic [DRF_IE_SRCS-1:0] dma_en = irq_enable_mask[DRF_IE_DMA_LSB +: DRF_IE_SRCS];
  wire logic clr_req = wr_cond && reg_wdata[DRF_ST_CCLR];

  // outputs registered; read data stands only the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
      cpu_irq_take <= '0;
      dma_irq_take <= '0;
      page_sel <= 8'h00;
      stack_addr <= 24'h00_0000;
      cache_fetch_ok <= 1'b0;
      cache_update_ok <= 1'b0;
      cache_invalidate <= 1'b0;
      ext_out0 <= 40'h00_0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      cpu_irq_take <= st_gie ? (irq_pending & cpu_en) : '0;
      dma_irq_take <= irq_pending & dma_en;
      page_sel <= data_page_ptr[7:0];
      stack_addr <= stack_top_ptr[23:0];
      cache_fetch_ok <= st_cen;
      cache_update_ok <= st_cen && !st_cfrz;
      cache_invalidate <= clr_req;
      ext_out0 <= ext_prec_regs[0];
    end
  end

  // assertions
  property p_cond_load;
    @(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == DRF_IDX_COND |=> cpu_condition_word == ($past(reg_wdata) & DRF_ST_KEEP & 32'hFFFF_EEFF
      | {23'h0, $past(repeat_running), 8'h00});
  endproperty
  a_cond_load: assert property (p_cond_load) else $error("condition word load mismatch");

  property p_load_beats_flags;
    @(posedge clk) disable iff (!rstn)
    wr_cond && alu_res.valid && alu_res.set_flags |=> cpu_condition_word[3:0] == $past(reg_wdata[3:0]);
  endproperty
  a_load_beats_flags: assert property (p_load_beats_flags) else $error("flag update beat load");

  property p_cclr_zero;
    @(posedge clk) disable iff (!rstn)
    cpu_condition_word[DRF_ST_CCLR] == 1'b0 && cpu_condition_word[15:14] == 2'b00 && cpu_condition_word[9] == 1'b0;
  endproperty
  a_cclr_zero: assert property (p_cclr_zero) else $error("reserved or clear bit reads one");

  property p_cclr_pulse;
    @(posedge clk) disable iff (!rstn)
    clr_req |=> cache_invalidate;
  endproperty
  a_cclr_pulse: assert property (p_cclr_pulse) else $error("cache clear not issued");

  property p_sat_pos;
    @(posedge clk) disable iff (!rstn)
    !reg_wr && res_int && alu_res.idx == DRF_IDX_EXT0 && alu_res.int_ovf && alu_res.ovf_pos
      && cpu_condition_word[DRF_ST_SAT] |=> ext_prec_regs[0][31:0] == DRF_SAT_POS;
  endproperty
  a_sat_pos: assert property (p_sat_pos) else $error("positive saturation missing");

  property p_exp_kept;
    @(posedge clk) disable iff (!rstn)
    !reg_wr && res_int && alu_res.idx == DRF_IDX_EXT0 |=> $stable(ext_prec_regs[0][39:32]);
  endproperty
  a_exp_kept: assert property (p_exp_kept) else $error("integer write changed exponent");

  property p_ovf_indep;
    @(posedge clk) disable iff (!rstn)
    !wr_cond && alu_res.valid && alu_res.set_flags |=> cpu_condition_word[DRF_ST_OVF] == $past(alu_res.int_ovf);
  endproperty
  a_ovf_indep: assert property (p_ovf_indep) else $error("overflow flag depends on mode");

  property p_gie_gate;
    @(posedge clk) disable iff (!rstn)
    !st_gie |=> cpu_irq_take == '0;
  endproperty
  a_gie_gate: assert property (p_gie_gate) else $error("interrupt taken with global enable low");

  property p_push;
    @(posedge clk) disable iff (!rstn)
    stack_push && !stack_pop && !wr_stack |=> stack_top_ptr == $past(stack_top_ptr) + 32'h0000_0001 ##1
      stack_addr == $past(stack_top_ptr[23:0]);
  endproperty
  a_push: assert property (p_push) else $error("push did not pre-increment");

  property p_ie_reserved;
    @(posedge clk) disable iff (!rstn)
    (irq_enable_mask & ~DRF_IE_KEEP) == 32'h0000_0000;
  endproperty
  a_ie_reserved: assert property (p_ie_reserved) else $error("enable mask reserved bit set");

  property p_freeze;
    @(posedge clk) disable iff (!rstn)
    st_cfrz && st_cen |=> cache_fetch_ok && !cache_update_ok;
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen cache allowed update");

  property p_cache_off;
    @(posedge clk) disable iff (!rstn)
    !st_cen |=> !cache_fetch_ok && !cache_update_ok;
  endproperty
  a_cache_off: assert property (p_cache_off) else $error("disabled cache still usable");

  property p_pop;
    @(posedge clk) disable iff (!rstn)
    stack_pop && !stack_push && !wr_stack |=> stack_top_ptr == $past(stack_top_ptr) - 32'h0000_0001;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not post-decrement");

  property p_ie_write;
    @(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == DRF_IDX_IRQEN |=> irq_enable_mask == ($past(reg_wdata) & DRF_IE_KEEP);
  endproperty
  a_ie_write: assert property (p_ie_write) else $error("enable mask write lost");

  property p_float_full;
    @(posedge clk) disable iff (!rstn)
    !reg_wr && alu_res.valid && alu_res.is_float && alu_res.idx == DRF_IDX_EXT0 |=> ext_prec_regs[0] == $past(alu_res.data);
  endproperty
  a_float_full: assert property (p_float_full) else $error("float result not stored in full");

  property p_rd_idle;
    @(posedge clk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");

  property p_page;
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> page_sel == $past(data_page_ptr[7:0]);
  endproperty
  a_page: assert property (p_page) else $error("page select does not follow pointer");

  c_sat: cover property (@(posedge clk) disable iff (!rstn) do_sat);
  c_load_and_flags: cover property (@(posedge clk) disable iff (!rstn) wr_cond && alu_res.valid);
  c_irq: cover property (@(posedge clk) disable iff (!rstn) cpu_irq_take != '0);
  c_push_pop: cover property (@(posedge clk) disable iff (!rstn) stack_push ##1 stack_pop);

endmodule // drf_cpu_register_file

// >>> testbench/drf_alu_model.sv
// far side model: alu and multiplier results, address unit writes
`timescale 1ns/1ps

module drf_alu_model
  import drf_pkg::*;
(
  input wire logic clk,
  output drf_result_t alu_res,
  output drf_aux_wr_t aux_wr_a,
  output drf_aux_wr_t aux_wr_b
);
  initial begin
    alu_res = '0;
    aux_wr_a = '0;
    aux_wr_b = '0;
  end

  // idle cycles carry inverted data so a stale value never looks valid
  task automatic send_res(input drf_result_t r, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    alu_res <= r;
    @(posedge clk);
    alu_res.valid <= 1'b0;
    alu_res.data <= ~r.data;
  endtask

  task automatic send_aux(input drf_aux_wr_t a, input drf_aux_wr_t b);
    @(posedge clk);
    aux_wr_a <= a;
    aux_wr_b <= b;
    @(posedge clk);
    aux_wr_a.valid <= 1'b0;
    aux_wr_b.valid <= 1'b0;
    aux_wr_a.data <= ~a.data;
    aux_wr_b.data <= ~b.data;
  endtask
endmodule // drf_alu_model

// >>> testbench/dsp_cpu_register_file_test.sv
// self-checking bench for the cpu register file
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end

module dsp_cpu_register_file_test
  import drf_pkg::*;
;
  logic clk, rstn, reg_wr, reg_rd, stack_push, stack_pop, repeat_running;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, st, v;
  logic [10:0] irq_pending, cpu_irq_take, dma_irq_take;
  logic [7:0] page_sel;
  logic [23:0] stack_addr;
  logic cache_fetch_ok, cache_update_ok, cache_invalidate;
  logic [39:0] ext_out0;
  drf_result_t alu_res;
  drf_aux_wr_t aux_wr_a, aux_wr_b;
  logic [39:0] mext [8];
  logic [31:0] mr [32];
  int fail_count, n_checks, k;

  drf_cpu_register_file drf_cpu_register_file_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_res(alu_res),
    .aux_wr_a(aux_wr_a), .aux_wr_b(aux_wr_b), .stack_push(stack_push), .stack_pop(stack_pop),
    .repeat_running(repeat_running), .irq_pending(irq_pending), .cpu_irq_take(cpu_irq_take),
    .dma_irq_take(dma_irq_take), .page_sel(page_sel), .stack_addr(stack_addr),
    .cache_fetch_ok(cache_fetch_ok), .cache_update_ok(cache_update_ok),
    .cache_invalidate(cache_invalidate), .ext_out0(ext_out0));
  drf_alu_model drf_alu_model_inst (.clk(clk), .alu_res(alu_res), .aux_wr_a(aux_wr_a), .aux_wr_b(aux_wr_b));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // reserved and self-clearing bits are dropped from the model at write time
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a < 5'h08) mext[a][31:0] = d;
    else if (a == DRF_IDX_COND) st = d & 32'hFFFF_2DFF;
    else if (a == DRF_IDX_IRQEN) mr[a] = d & 32'h07FF_07FF;
    else if (a < 5'h1C) mr[a] = d;
  endtask

  function automatic logic [31:0] exp_rd(input logic [4:0] a);
    if (a < 5'h08) return mext[a][31:0];
    if (a == DRF_IDX_COND) return {st[31:9], repeat_running, st[7:0]};
    if (a > 5'h1B) return 32'h0000_0000;
    return mr[a];
  endfunction

  task automatic chk_rd(input logic [4:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK("read data", exp_rd(a), reg_rdata)
  endtask

  task automatic res(input logic [4:0] i, input logic f, input logic [39:0] d, input logic o, p, c, u, sf);
    drf_result_t r;
    r = '{valid: 1'b1, idx: i, is_float: f, data: d, int_ovf: o, ovf_pos: p, carry: c, unf: u, set_flags: sf};
    drf_alu_model_inst.send_res(r, $urandom % 2);
    v = d[31:0];
    if (!f && o && st[7]) v = p ? 32'h7FFF_FFFF : 32'h8000_0000;
    if (f && i < 5'h08) mext[i] = d;
    else if (!f && i < 5'h08) mext[i][31:0] = v;
    else if (!f) mr[i] = v;
    if (sf) begin
      st[0] = c;
      st[1] = o;
      st[2] = f ? (d[39:32] == 8'h80 && v == 0) : (v == 0);
      st[3] = v[31];
      st[4] = u;
      st[5] = st[5] | o;
      st[6] = st[6] | u;
    end
  endtask

  // unit a lands after unit b so it wins a shared target
  task automatic aux(input drf_aux_wr_t a, input drf_aux_wr_t b);
    drf_alu_model_inst.send_aux(a, b);
    if (b.valid) mr[8 + b.sel] = b.data;
    if (a.valid) mr[8 + a.sel] = a.data;
  endtask

  task automatic stk(input logic pu, input logic po);
    @(posedge clk);
    stack_push <= pu;
    stack_pop <= po;
    @(posedge clk);
    stack_push <= 1'b0;
    stack_pop <= 1'b0;
    if (pu && !po) mr[DRF_IDX_STACK]++;
    else if (po && !pu) mr[DRF_IDX_STACK]--;
  endtask

  initial begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0000_0000;
    stack_push = 1'b0;
    stack_pop = 1'b0;
    repeat_running = 1'b0;
    irq_pending = 11'h000;
    st = 32'h0000_0000;
    foreach (mext[i]) mext[i] = '0;
    foreach (mr[i]) mr[i] = '0;
    void'($urandom(31633));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k < 32; k++) chk_rd(k[4:0]);
    for (k = 0; k < 32; k++) wr(k[4:0], $urandom());
    for (k = 0; k < 32; k++) chk_rd(k[4:0]);
    wr(DRF_IDX_PAGE, 32'h0000_00A5);
    settle(2);
    `CHK("page select", 8'hA5, page_sel)
    wr(DRF_IDX_STACK, 32'h00FF_FFFF);
    stk(1'b1, 1'b0);
    stk(1'b1, 1'b1);
    settle(2);
    `CHK("stack address", 24'h00_0000, stack_addr)
    chk_rd(DRF_IDX_STACK);
    settle(1);
    `CHK("idle read data", 32'h0000_0000, reg_rdata)
    stk(1'b0, 1'b1);
    chk_rd(DRF_IDX_STACK);
    // saturation on, then off; latched overflow must outlive later clean results
    wr(DRF_IDX_COND, 32'h0000_0080);
    res(5'h00, 1'b1, 40'h05_4000_1234, 0, 0, 0, 0, 1);
    res(5'h00, 1'b0, 40'h00_1234_5678, 1, 1, 1, 0, 1);
    settle(2);
    `CHK("ext reg 0", {8'h05, 32'h7FFF_FFFF}, ext_out0)
    chk_rd(DRF_IDX_COND);
    res(5'h01, 1'b0, 40'hFF_0000_0001, 1, 0, 0, 0, 1);
    chk_rd(5'h01);
    chk_rd(DRF_IDX_COND);
    wr(DRF_IDX_COND, 32'h0000_0000);
    res(5'h09, 1'b0, 40'h00_1234_5678, 1, 1, 0, 0, 1);
    chk_rd(DRF_IDX_COND);
    res(5'h0A, 1'b0, '0, 0, 0, 0, 0, 1);
    res(5'h0B, 1'b1, 40'h01_0000_0000, 0, 0, 0, 1, 0);
    res(5'h02, 1'b1, 40'h81_8000_0000, 0, 0, 0, 1, 1);
    for (k = 0; k < 16; k++) chk_rd(k[4:0]);
    chk_rd(DRF_IDX_COND);
    @(posedge clk);
    repeat_running <= 1'b1;
    fork
      wr(DRF_IDX_COND, 32'h0000_2000);
      drf_alu_model_inst.send_res('{1'b1, 5'h03, 1'b0, '0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1}, 0);
    join
    mext[3][31:0] = 32'h0000_0000;
    chk_rd(DRF_IDX_COND);
    chk_rd(5'h03);
    @(posedge clk);
    repeat_running <= 1'b0;
    aux('{1'b1, 3'h2, 32'hA5A5_0001}, '{1'b1, 3'h2, 32'h5A5A_0002});
    aux('{1'b0, 3'h0, 32'h0000_0000}, '{1'b1, 3'h5, 32'h0BAD_F00D});
    for (k = 8; k < 16; k++) chk_rd(k[4:0]);
    for (k = 0; k < 6; k++) begin
      wr(DRF_IDX_IRQEN, $urandom());
      wr(DRF_IDX_COND, {18'h0, k[0], 13'h0});
      @(posedge clk);
      irq_pending <= 11'($urandom());
      settle(3);
      `CHK("cpu take", irq_pending & mr[DRF_IDX_IRQEN][10:0] & {11{k[0]}}, cpu_irq_take)
      `CHK("dma take", irq_pending & mr[DRF_IDX_IRQEN][26:16], dma_irq_take)
    end
    for (k = 0; k < 4; k++) begin
      wr(DRF_IDX_COND, {20'h0, k[1], k[0], 10'h0});
      settle(2);
      `CHK("cache fetch", k[1], cache_fetch_ok)
      `CHK("cache update", k[1] & ~k[0], cache_update_ok)
    end
    wr(DRF_IDX_COND, 32'h0000_1800);
    v = 32'h0000_0000;
    repeat (4) begin
      #1 v += cache_invalidate;
      @(posedge clk);
    end
    `CHK("invalidate pulses", 32'h0000_0001, v)
    chk_rd(DRF_IDX_COND);
    give_verdict();
  end
endmodule // dsp_cpu_register_file_test
